// ### sfcd_checker.sv
/*
  sfcd_checker: port-level assertions for sfcd_decoder.
  assumes core_clk_i samples the pins and sys_rst_i is the only reset.
*/
`timescale 1ns/10ps
module sfcd_checker (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hw_reset_n_i,
  input wire logic chip_sel_n_i,
  input wire logic sclk_i,
  input wire logic four_line_command_mode_i,
  input wire logic write_done_i,
  input wire logic [3:0] sio_o,
  input wire logic [3:0] sio_oe_n_o,
  input wire logic write_enable_latch_o,
  input wire logic cmd_active_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // long idle and pin reset, longer than the 3-ff sampler
  sequence s_idle; chip_sel_n_i [*8]; endsequence
  sequence s_pin_low; !hw_reset_n_i [*6]; endsequence
  sequence s_held; !chip_sel_n_i [*5]; endsequence
  chk_idle_released: assert property (s_idle |-> sio_oe_n_o == 4'hf && !cmd_active_o)
    else $error("lines driven while deselected");
  chk_held_active: assert property (s_held |-> cmd_active_o)
    else $error("frame not active with select low");
  chk_cs_release: assert property ($rose(chip_sel_n_i) |-> ##[1:6] sio_oe_n_o == 4'hf)
    else $error("lines not released after deselect");
  chk_lane_width: assert property (sio_oe_n_o != 4'hf |-> sio_oe_n_o == (four_line_command_mode_i ? 4'h0 : 4'hd))
    else $error("wrong lines driven");
  chk_out_stands: assert property ((sclk_i && sio_oe_n_o != 4'hf) [*6] |-> $stable(sio_o))
    else $error("output moved while clock high");
  chk_pin_clear: assert property (s_pin_low |=> !write_enable_latch_o)
    else $error("latch survives reset pin");
  chk_done_clear: assert property (write_done_i |-> ##[1:3] !write_enable_latch_o)
    else $error("latch survives completion");
  chk_set_framed: assert property ($rose(write_enable_latch_o) |-> cmd_active_o || $past(cmd_active_o))
    else $error("latch set outside a frame");
endmodule : sfcd_checker
bind sfcd_decoder sfcd_checker u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_reset_n_i(hw_reset_n_i),
  .chip_sel_n_i(chip_sel_n_i), .sclk_i(sclk_i), .four_line_command_mode_i(four_line_command_mode_i),
  .write_done_i(write_done_i), .sio_o(sio_o), .sio_oe_n_o(sio_oe_n_o),
  .write_enable_latch_o(write_enable_latch_o), .cmd_active_o(cmd_active_o));

// ### sfcd_decoder.sv
/*
  sfcd_decoder: decodes basic serial flash commands, keeps the write enable latch
  and shifts identification and register bytes out.
  assumes the serial clock is far slower than core_clk_i (at least 4x) so each
  link edge is seen by sampling; program/erase engines live elsewhere and
  report busy and completion pulses on the same clock.
*/
`timescale 1ns/10ps
module sfcd_decoder import sfcd_pkg::*; #(
  parameter logic [7:0] MANUF_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] MEM_TYPE_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] DENSITY_CODE = 8'h21, // arbitrary value
  parameter logic [7:0] SIGNATURE_CODE = 8'h4e // arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hw_reset_n_i, // reset pin, active low
  input wire logic chip_sel_n_i, // chip select pin, active low
  input wire logic sclk_i, // serial clock pin
  input wire logic [3:0] sio_i, // data lines in
  output logic [3:0] sio_o, // data lines out
  output logic [3:0] sio_oe_n_o, // low while driving
  input wire logic four_line_command_mode_i, // opcode on four lines
  input wire logic write_in_progress_flag_i, // program/erase/register write busy
  input wire logic prog_erase_busy_i, // program or erase busy
  input wire logic [5:0] status_upper_i, // status bits 7..2
  input wire logic [7:0] config_reg_i, // configuration byte
  input wire logic write_done_i, // pulse: altering command completed
  output logic write_enable_latch_o, // latch level
  output logic cmd_active_o // high while a frame is decoded
);
  // three-stage samplers for control pins, two stages for data lines
  logic [2:0] cs_sync;
  logic [2:0] clk_sync;
  logic [2:0] rst_sync;
  logic [3:0] sio_s1;
  logic [3:0] sio_s2;
  // block state
  sfcd_state_t state;
  sfcd_src_t src;
  logic [4:0] bit_cnt; // counts bits or nibbles received
  logic [7:0] shift_in; // opcode / address assembly
  logic [7:0] shift_out; // byte being sent
  logic [2:0] out_bit; // bit index within byte
  logic [1:0] byte_idx; // position in id stream
  logic swap_order; // two-byte id starts with device code
  logic write_enable_latch;
  logic [3:0] sio_drv;
  logic drive_en;

  // edge detection uses only the 2nd and 3rd stages
  wire cs_low = ~cs_sync[1] & ~cs_sync[2];
  wire cs_rise = cs_sync[1] & cs_sync[2] & 1'b1 & ~cs_low;
  wire clk_rise = clk_sync[1] & ~clk_sync[2];
  wire clk_fall = ~clk_sync[1] & clk_sync[2];
  wire pin_reset = ~rst_sync[1] & ~rst_sync[2];
  wire four_line = four_line_command_mode_i;
  // in single-line mode only line 0 is taken; lines 3..1 ignored
  wire [7:0] next_shift_in = four_line ? {shift_in[3:0], sio_s2} : {shift_in[6:0], sio_s2[0]};
  wire [4:0] opc_last = four_line ? BIT_CNT_FOUR_LINE : BIT_CNT_ONE_LINE;
  wire opc_done = (state == SFCD_OPCODE) & clk_rise & (bit_cnt == opc_last);
  wire hdr_done = (state == SFCD_HEADER) & clk_rise & (bit_cnt == TWO_BYTE_HDR_LAST);
  // status byte: latch in bit 1, busy in bit 0
  wire [7:0] status_byte = {status_upper_i, write_enable_latch, write_in_progress_flag_i};
  // a four-line byte is two nibbles: index 0 then 1; one-line counts 7 down to 0
  wire byte_end = four_line ? (out_bit == 3'h1) : (out_bit == 3'h0);

  // pick the byte a source sends at a given position
  function automatic logic [7:0] pick_byte(input sfcd_src_t s, input logic [1:0] idx,
                                           input logic swp, input logic [7:0] st,
                                           input logic [7:0] cf);
    logic [7:0] b;
    b = 8'h00;
    case (s)
      SFCD_SRC_ID: b = (idx == 2'h0) ? MANUF_CODE : (idx == 2'h1) ? MEM_TYPE_CODE : DENSITY_CODE;
      SFCD_SRC_SIG: b = SIGNATURE_CODE;
      SFCD_SRC_TWO: b = (idx[0] ^ swp) ? SIGNATURE_CODE : MANUF_CODE;
      SFCD_SRC_STAT: b = st;
      SFCD_SRC_CFG: b = cf;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : pick_byte

  // next index in a stream; registers repeat, id wraps over three bytes
  wire [1:0] next_idx = (src == SFCD_SRC_ID) ? ((byte_idx == ID_BYTES - 2'h1) ? 2'h0 : byte_idx + 2'h1)
                                              : byte_idx + 2'h1;
  wire [7:0] next_byte = pick_byte(src, next_idx, swap_order, status_byte, config_reg_i);

  // opcode classification
  wire is_id = (shift_in == CMD_ID_READ) & ~four_line;
  wire is_qid = (shift_in == CMD_FOUR_LINE_ID) & four_line;
  wire [7:0] opc = next_shift_in;

  // pin samplers
  always_ff @(posedge core_clk_i) begin
    cs_sync <= {cs_sync[1:0], chip_sel_n_i};
    clk_sync <= {clk_sync[1:0], sclk_i};
    rst_sync <= {rst_sync[1:0], hw_reset_n_i};
    sio_s1 <= sio_i;
    sio_s2 <= sio_s1;
  end

  // frame and command sequencing
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state <= SFCD_IDLE;
      src <= SFCD_SRC_ID;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      out_bit <= 3'h0;
      byte_idx <= 2'h0;
      swap_order <= 1'b0;
      drive_en <= 1'b0;
    end else if (!cs_low) begin
      // deselect ends any command and returns to standby
      state <= SFCD_IDLE;
      drive_en <= 1'b0;
      bit_cnt <= 5'h00;
    end else begin
      case (state)
        SFCD_IDLE: begin
          state <= SFCD_OPCODE;
          bit_cnt <= 5'h00;
        end
        SFCD_OPCODE: begin
          if (clk_rise) begin
            shift_in <= next_shift_in;
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (opc_done) begin
            bit_cnt <= 5'h00;
            byte_idx <= 2'h0;
            out_bit <= four_line ? 3'h0 : 3'h7;
            if ((opc == CMD_ID_READ && !four_line) || (opc == CMD_FOUR_LINE_ID && four_line)) begin
              // id read not decoded during program/erase
              state <= prog_erase_busy_i ? SFCD_IGNORE : SFCD_SEND;
              src <= SFCD_SRC_ID;
              shift_out <= MANUF_CODE;
            end else if (opc == CMD_SIGNATURE) begin
              state <= SFCD_SEND;
              src <= SFCD_SRC_SIG;
              shift_out <= SIGNATURE_CODE;
            end else if (opc == CMD_TWO_BYTE_ID && !four_line) begin
              state <= SFCD_HEADER;
              src <= SFCD_SRC_TWO;
            end else if (opc == CMD_STATUS_READ) begin
              state <= SFCD_SEND;
              src <= SFCD_SRC_STAT;
              shift_out <= status_byte;
            end else if (opc == CMD_CONFIG_READ) begin
              state <= SFCD_SEND;
              src <= SFCD_SRC_CFG;
              shift_out <= config_reg_i;
            end else begin
              state <= SFCD_IGNORE;
            end
          end
        end
        SFCD_HEADER: begin
          if (clk_rise) begin
            shift_in <= {shift_in[6:0], sio_s2[0]};
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (hdr_done) begin
            // address bit 0 picks the order of the two codes
            swap_order <= sio_s2[0];
            shift_out <= sio_s2[0] ? SIGNATURE_CODE : MANUF_CODE;
            out_bit <= 3'h7;
            byte_idx <= 2'h0;
            state <= SFCD_SEND;
          end
        end
        SFCD_SEND: begin
          // data changes on falling edges, msb first
          if (clk_fall) begin
            drive_en <= 1'b1;
            if (drive_en) begin
              if (byte_end) begin
                // streams repeat while clocks continue
                byte_idx <= next_idx;
                shift_out <= next_byte;
                out_bit <= four_line ? 3'h0 : 3'h7;
              end else if (four_line) begin
                shift_out <= {shift_out[3:0], 4'h0};
                out_bit <= out_bit + 3'h1;
              end else begin
                shift_out <= {shift_out[6:0], 1'b0};
                out_bit <= out_bit - 3'h1;
              end
            end
          end
        end
        SFCD_IGNORE: state <= SFCD_IGNORE;
        default: state <= SFCD_IDLE;
      endcase
    end
  end

  // write enable latch; clears win over a simultaneous set
  wire wel_set = opc_done & (opc == CMD_WRITE_ENABLE);
  wire wel_clr = (opc_done & (opc == CMD_WRITE_DISABLE)) | write_done_i | pin_reset;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      write_enable_latch <= 1'b0; // power-up clears the latch
    end else if (wel_clr) begin
      write_enable_latch <= 1'b0;
    end else if (wel_set) begin
      write_enable_latch <= 1'b1;
    end
  end

  // output lines: one-line data on line 1, four-line on all lines
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sio_drv <= 4'h0;
    end else begin
      sio_drv <= four_line ? shift_out[7:4] : {2'b00, shift_out[7], 1'b0};
    end
  end

  assign sio_o = sio_drv;
  assign sio_oe_n_o = (drive_en && state == SFCD_SEND) ? (four_line ? 4'h0 : 4'hd) : 4'hf;
  assign write_enable_latch_o = write_enable_latch;
  assign cmd_active_o = (state != SFCD_IDLE);

  // unused decode helpers kept out of logic
  wire unused_ok = is_id | is_qid | cs_rise;
endmodule : sfcd_decoder

// ### sfcd_host.sv
/*
  sfcd_host: behavioural host controller, mode 0, clock idles low between frames.
  assumes clk_i is the core clock; one serial bit phase is 8 core cycles.
*/
`timescale 1ns/10ps
module sfcd_host (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] sio_o,
  input wire logic [3:0] sio_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 4'h5;
  end
  // half of the 160 ns serial period
  task automatic half();
    repeat (8) @(negedge clk_i);
  endtask : half
  // tx holds opcode then header bytes, left aligned; rx collects n_rx bytes
  task automatic frame(input logic quad, input logic [31:0] tx, input int n_tx, input int n_rx,
                       output logic [31:0] rx);
    int i;
    int per;
    per = quad ? 2 : 8;
    rx = '0;
    cs_n_o = 1'b0;
    half();
    for (i = 0; i < per * (n_tx + n_rx); i++) begin
      if (i < per * n_tx) begin
        // upper lines carry junk in single-line mode
        sio_o = quad ? tx[31 - 4 * i -: 4] : {{3{~tx[31 - i]}}, tx[31 - i]};
      end else begin
        sio_o = ~sio_o; // released: toggling, never a stale value
      end
      half();
      sclk_o = 1'b1;
      if (i >= per * n_tx) begin
        rx = quad ? {rx[27:0], sio_i} : {rx[30:0], sio_i[1]};
      end
      half();
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1; // may end at any byte
    sio_o = ~sio_o;
    half();
    half();
  endtask : frame
endmodule : sfcd_host

// ### sfcd_pkg.sv
/*
  sfcd_pkg: constants for the basic serial flash command decoder.
  assumes one core clock; the serial link is sampled, not used as a clock.
*/
// Functional notes
// - write enable command sets the latch
// - opcode as 8 single-line or 2 four-line clocks
// - write disable command clears the latch
// - latch cleared by reset, power-up, completed writes
// - id read sends manufacturer, type, density bytes
// - id read ignored while program or erase busy
// - legacy signature command outputs one signature byte
// - signature repeats until chip select rises
// - address bit zero selects code order, msb first
// - two-byte id codes alternate until deselect
// - four-line id streams three bytes continuously
// - status read answers anytime, sends status byte
// - configuration read answers anytime, sends config byte
// - latch in bit one, busy flag bit zero
package sfcd_pkg;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_ID_READ = 8'h9f;
  localparam logic [7:0] CMD_SIGNATURE = 8'hab;
  localparam logic [7:0] CMD_TWO_BYTE_ID = 8'h90;
  localparam logic [7:0] CMD_FOUR_LINE_ID = 8'haf;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_CONFIG_READ = 8'h15;
  localparam int STAT_WEL_BIT = 1; // latch position in status
  localparam int STAT_WIP_BIT = 0; // busy position in status
  localparam logic [4:0] BIT_CNT_ONE_LINE = 5'h07; // last opcode bit, one line
  localparam logic [4:0] BIT_CNT_FOUR_LINE = 5'h01; // last opcode nibble
  localparam logic [4:0] TWO_BYTE_HDR_LAST = 5'h17; // 24 header bits, last index
  localparam logic [1:0] ID_BYTES = 2'h3; // bytes in the id stream
  typedef enum logic [2:0] {
    SFCD_IDLE, SFCD_OPCODE, SFCD_HEADER, SFCD_SEND, SFCD_IGNORE
  } sfcd_state_t;
  typedef enum logic [2:0] {
    SFCD_SRC_ID, SFCD_SRC_SIG, SFCD_SRC_TWO, SFCD_SRC_STAT, SFCD_SRC_CFG
  } sfcd_src_t;
endpackage : sfcd_pkg

// ### testbench.sv
/*
  testbench: table of command frames through the host model, then reset and busy cases.
  assumes sfcd_host and sfcd_checker compile beside the design.
*/
`timescale 1ns/10ps
module testbench import sfcd_pkg::*;;
  localparam logic [7:0] M = 8'h5a, T = 8'h3c, D = 8'h21, S = 8'h4e; // arbitrary id values
  localparam logic [5:0] SU = 6'h2a;
  localparam logic [7:0] CF = 8'h93;
  typedef struct {logic q; logic w; logic [31:0] tx; int ntx; int nrx; logic [31:0] e; logic write_enable_latch;} sfcd_row_t;
  logic core_clk_i = 0, sys_rst_i = 1, hw_reset_n_i = 1, mode = 0, write_in_progress_flag = 1, pe_busy = 0, done = 0, drove = 0;
  logic [3:0] host_sio, dut_sio, dut_oe_n, line;
  logic cs_n, sclk, write_enable_latch, active;
  logic [31:0] rx;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  sfcd_row_t rows [13];
  // wire level: the driver whose enable is low wins
  assign line = (dut_oe_n & host_sio) | (~dut_oe_n & dut_sio);
  sfcd_host host (.clk_i(core_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(host_sio), .sio_i(line));
  sfcd_decoder #(.MANUF_CODE(M), .MEM_TYPE_CODE(T), .DENSITY_CODE(D), .SIGNATURE_CODE(S)) dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_reset_n_i(hw_reset_n_i), .chip_sel_n_i(cs_n),
    .sclk_i(sclk), .sio_i(line), .sio_o(dut_sio), .sio_oe_n_o(dut_oe_n), .four_line_command_mode_i(mode),
    .write_in_progress_flag_i(write_in_progress_flag), .prog_erase_busy_i(pe_busy), .status_upper_i(SU), .config_reg_i(CF),
    .write_done_i(done), .write_enable_latch_o(write_enable_latch), .cmd_active_o(active));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // watch for any drive during refused frames
  always @(posedge core_clk_i) begin
    if (dut_oe_n !== 4'hf) drove <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_val(nm, {31'h0, e}, {31'h0, g});
  endtask : cmp_bit
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    rows = '{'{0, 1, {CMD_WRITE_ENABLE, 24'h0}, 1, 0, 0, 1},
      '{0, 1, {CMD_STATUS_READ, 24'h0}, 1, 2, {16'h0, SU, 2'b11, SU, 2'b11}, 1},
      '{1, 1, {CMD_WRITE_DISABLE, 24'h0}, 1, 0, 0, 0},
      '{1, 0, {CMD_STATUS_READ, 24'h0}, 1, 1, {24'h0, SU, 2'b00}, 0},
      '{1, 1, {CMD_WRITE_ENABLE, 24'h0}, 1, 0, 0, 1},
      '{0, 1, {CMD_CONFIG_READ, 24'h0}, 1, 2, {16'h0, CF, CF}, 1},
      '{0, 1, {CMD_ID_READ, 24'h0}, 1, 1, {24'h0, M}, 1},
      '{0, 1, {CMD_ID_READ, 24'h0}, 1, 4, {M, T, D, M}, 1},
      '{0, 1, {CMD_SIGNATURE, 24'h0}, 1, 2, {16'h0, S, S}, 1},
      '{0, 1, {CMD_TWO_BYTE_ID, 24'h0}, 4, 3, {8'h0, M, S, M}, 1},
      '{0, 1, {CMD_TWO_BYTE_ID, 24'h1}, 4, 3, {8'h0, S, M, S}, 1},
      '{1, 1, {CMD_FOUR_LINE_ID, 24'h0}, 1, 4, {M, T, D, M}, 1},
      '{1, 1, {CMD_CONFIG_READ, 24'h0}, 1, 1, {24'h0, CF}, 1}};
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 0;
    repeat (4) @(negedge core_clk_i);
    cmp_bit("wel after reset", 0, write_enable_latch);
    cmp_val("oe after reset", 32'hf, {28'h0, dut_oe_n});
    cmp_bit("active after reset", 0, active);
    foreach (rows[k]) begin
      mode = rows[k].q;
      write_in_progress_flag = rows[k].w;
      host.frame(rows[k].q, rows[k].tx, rows[k].ntx, rows[k].nrx, rx);
      cmp_val("read data", rows[k].e, rx);
      cmp_bit("wel", rows[k].write_enable_latch, write_enable_latch);
    end
    done = 1; // completion pulse clears the latch
    @(negedge core_clk_i);
    done = 0;
    repeat (2) @(negedge core_clk_i);
    cmp_bit("wel after done", 0, write_enable_latch);
    host.frame(1, {CMD_WRITE_ENABLE, 24'h0}, 1, 0, rx);
    hw_reset_n_i = 0;
    repeat (8) @(negedge core_clk_i);
    hw_reset_n_i = 1;
    repeat (8) @(negedge core_clk_i);
    cmp_bit("wel after pin", 0, write_enable_latch);
    mode = 0;
    host.frame(0, {CMD_WRITE_ENABLE, 24'h0}, 1, 0, rx); // host enables before altering
    pe_busy = 1;
    drove = 0;
    host.frame(0, {CMD_ID_READ, 24'h0}, 1, 2, rx);
    cmp_bit("drove while busy", 0, drove);
    host.frame(0, {CMD_STATUS_READ, 24'h0}, 1, 1, rx); // host polls busy flag
    cmp_val("status while busy", {24'h0, SU, 2'b11}, rx);
    pe_busy = 0;
    final_report();
  end
endmodule : testbench
